//--- pkg/ufs_pkg.sv
// Purpose: shared constants for the usb address and status register pair
// Assumes: one system clock at 20 MHz, byte-wide mcu memory port
// Notes: offsets are mcu data-space byte addresses
package ufs_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FADR_W = 7;

    localparam logic [15:0] OFS_STATUS = 16'hfffe;
    localparam logic [15:0] OFS_FADR = 16'hffff;
    localparam logic [15:0] OFS_VECTOR = 16'hffb2;

    localparam logic [7:0] RST_FADR = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;

    localparam int BIT_BUS_RESET = 7;
    localparam int BIT_SUSPEND = 6;
    localparam int BIT_RESUME = 5;
    localparam int BIT_SOF = 4;
    localparam int BIT_PSEUDO_SOF = 3;
    localparam int BIT_SETUP = 2;
    localparam int BIT_RSVD = 1;
    localparam int BIT_SETUP_OW = 0;

    // flags cleared by any write to the interrupt vector register
    localparam logic [7:0] VEC_CLR_MASK = 8'h78;
    // bits that exist in hardware; bit 1 reads zero
    localparam logic [7:0] IMPL_MASK = 8'hfd;

    localparam int CLK_KHZ = 20000;
    localparam int FRAME_PERIOD_US = 1000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_US * CLK_KHZ / 1000;
endpackage

//--- rtl/ufs_flag_cell.sv
// Purpose: one sticky status flag
// Assumes: set and clear are single-cycle pulses on clk_i
// Notes: set wins over clear so an event is never lost
module ufs_flag_cell (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);
    logic flag_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else if (set_i) begin
            flag_q <= 1'b1;
        end else if (clr_i) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_o = flag_q;
endmodule // ufs_flag_cell

//--- rtl/ufs_regs.sv
// Purpose: usb function address and status flag registers
// Assumes: event inputs come from usb logic on clk_i, one-cycle pulses
// Notes: reads answer one cycle after the strobe from a flop
//
// Contract
// RL1 - address register bits 6:0 hold the device address, read and write
// RL2 - address bit 7 is reserved, reads zero, never written
// RL3 - device address clears on reset and on every usb bus reset
// RL4 - firmware writes the host-given address after a set address request
// RL5 - status flags read only, cleared at reset, bits as fixed
// RL6 - suspend flag sets when suspend is detected
// RL7 - resume flag sets when resume is detected
// RL8 - suspend, resume, sof, pseudo sof clear on interrupt vector write
// RL9 - pseudo sof flag sets on each 1 ms tick while unlocked
// RL10 - writes to the status register change no flag
module ufs_regs #(
    parameter int FRAME_CYCLES = ufs_pkg::FRAME_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_wr_i,
    input wire logic mem_rd_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    input wire logic bus_reset_i,
    input wire logic suspend_det_i,
    input wire logic resume_det_i,
    input wire logic sof_det_i,
    input wire logic setup_det_i,
    input wire logic setup_ow_det_i,
    input wire logic timer_locked_i,
    input wire logic [7:0] flag_clr_i,
    output logic [6:0] device_address_field_o,
    output logic [7:0] usb_status_flags_o,
    output logic pseudo_sof_o
);
    localparam int CNT_W = $clog2(FRAME_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FRAME_CYCLES - 1);
    localparam int GAP_W = CNT_W + 1;
    localparam logic [GAP_W-1:0] GAP_FULL = GAP_W'(FRAME_CYCLES);

    logic [6:0] fadr_q;
    logic [6:0] fadr_d;
    logic [7:0] rdata_q;
    logic [CNT_W-1:0] frame_cnt_q;
    logic pseudo_sof_q;
    logic [GAP_W-1:0] gap_q;
    logic vec_wr;
    logic fadr_wr;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] flags;

    assign vec_wr = mem_wr_i && (mem_addr_i == ufs_pkg::OFS_VECTOR);
    assign fadr_wr = mem_wr_i && (mem_addr_i == ufs_pkg::OFS_FADR);

    // address register; bus reset beats a write in the same cycle
    always_comb begin
        fadr_d = fadr_q;
        if (bus_reset_i) begin
            fadr_d = ufs_pkg::RST_FADR[6:0]; // RL3
        end else if (fadr_wr) begin
            fadr_d = mem_wdata_i[6:0]; // RL1 RL4
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fadr_q <= ufs_pkg::RST_FADR[6:0]; // RL3
        end else begin
            fadr_q <= fadr_d;
        end
    end

    // local frame timer; restarts on a real sof so ticks stay in phase
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            frame_cnt_q <= '0;
            pseudo_sof_q <= 1'b0;
        end else if (timer_locked_i || sof_det_i) begin
            frame_cnt_q <= '0;
            pseudo_sof_q <= 1'b0;
        end else if (frame_cnt_q == CNT_LAST) begin
            frame_cnt_q <= '0;
            pseudo_sof_q <= 1'b1; // RL9
        end else begin
            frame_cnt_q <= frame_cnt_q + 1'b1;
            pseudo_sof_q <= 1'b0;
        end
    end

    // check-only helper, kept apart from frame_cnt_q so a slip shows
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || timer_locked_i || sof_det_i) begin
            gap_q <= '0;
        end else if (pseudo_sof_q) begin
            gap_q <= GAP_W'(1);
        end else begin
            gap_q <= gap_q + 1'b1;
        end
    end

    // event to flag mapping; status-register writes reach nothing here
    always_comb begin
        set_vec = 8'h00;
        set_vec[ufs_pkg::BIT_BUS_RESET] = bus_reset_i;
        set_vec[ufs_pkg::BIT_SUSPEND] = suspend_det_i; // RL6
        set_vec[ufs_pkg::BIT_RESUME] = resume_det_i; // RL7
        set_vec[ufs_pkg::BIT_SOF] = sof_det_i;
        set_vec[ufs_pkg::BIT_PSEUDO_SOF] = pseudo_sof_q; // RL9
        set_vec[ufs_pkg::BIT_SETUP] = setup_det_i;
        set_vec[ufs_pkg::BIT_SETUP_OW] = setup_ow_det_i;
        clr_vec = flag_clr_i | (vec_wr ? ufs_pkg::VEC_CLR_MASK : 8'h00); // RL8
    end

    // bit 1 has no cell, so it can never read one
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            if (ufs_pkg::IMPL_MASK[gi]) begin : g_cell
                ufs_flag_cell u_cell (
                    .clk_i(clk_i),
                    .rst_n_i(rst_n_i),
                    .set_i(set_vec[gi]),
                    .clr_i(clr_vec[gi]),
                    .flag_o(flags[gi])
                ); // RL5 RL10
            end else begin : g_rsvd
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    // read port; unmapped addresses return zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_q <= 8'h00;
        end else if (mem_rd_i) begin
            unique case (mem_addr_i)
                ufs_pkg::OFS_FADR: rdata_q <= {1'b0, fadr_q}; // RL1 RL2
                ufs_pkg::OFS_STATUS: rdata_q <= flags; // RL5
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign mem_rdata_o = rdata_q;
    assign device_address_field_o = fadr_q;
    assign usb_status_flags_o = flags;
    assign pseudo_sof_o = pseudo_sof_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_fadr_write: assert property ( // RL1
        fadr_wr && !bus_reset_i |=> fadr_q == $past(mem_wdata_i[6:0]))
        else $error("address write not stored");
    chk_fadr_rsvd_rd: assert property ( // RL2
        mem_rd_i && mem_addr_i == ufs_pkg::OFS_FADR |=> mem_rdata_o[7] == 1'b0)
        else $error("reserved address bit read nonzero");
    chk_fadr_busrst: assert property ( // RL3
        bus_reset_i |=> fadr_q == 7'h00)
        else $error("bus reset left address set");
    chk_susp_set: assert property ( // RL6
        suspend_det_i |=> usb_status_flags_o[ufs_pkg::BIT_SUSPEND])
        else $error("suspend flag not set");
    chk_res_set: assert property ( // RL7
        resume_det_i |=> usb_status_flags_o[ufs_pkg::BIT_RESUME])
        else $error("resume flag not set");
    chk_vec_clear: assert property ( // RL8
        vec_wr && !suspend_det_i && flag_clr_i == 8'h00
        |=> !usb_status_flags_o[ufs_pkg::BIT_SUSPEND])
        else $error("vector write did not clear suspend");
    chk_pseudo_sof_set: assert property ( // RL9
        pseudo_sof_q |=> usb_status_flags_o[ufs_pkg::BIT_PSEUDO_SOF])
        else $error("pseudo sof flag not set");
    chk_pseudo_sof_locked: assert property ( // RL9
        timer_locked_i |=> !pseudo_sof_q)
        else $error("pseudo sof while locked");
    chk_status_ro: assert property ( // RL10
        mem_wr_i && mem_addr_i == ufs_pkg::OFS_STATUS && !vec_wr
        && set_vec == 8'h00 && flag_clr_i == 8'h00
        |=> $stable(usb_status_flags_o))
        else $error("status write changed a flag");
    chk_rsvd_flag: assert property ( // RL5
        usb_status_flags_o[ufs_pkg::BIT_RSVD] == 1'b0)
        else $error("reserved status bit set");

    // read path
    chk_addr_rd: assert property ( // RL1
        mem_rd_i && mem_addr_i == ufs_pkg::OFS_FADR
        |=> mem_rdata_o[6:0] == $past(device_address_field_o))
        else $error("address read data wrong");
    chk_status_rd: assert property ( // RL5
        mem_rd_i && mem_addr_i == ufs_pkg::OFS_STATUS
        |=> mem_rdata_o == $past(usb_status_flags_o))
        else $error("status read data wrong");
    chk_rdata_hold: assert property ( // RL5
        !mem_rd_i |=> $stable(mem_rdata_o))
        else $error("read data moved without a read");

    // flag behaviour
    chk_vec_clr_all: assert property ( // RL8
        vec_wr && (set_vec & ufs_pkg::VEC_CLR_MASK) == 8'h00
        |=> (usb_status_flags_o & ufs_pkg::VEC_CLR_MASK) == 8'h00)
        else $error("vector write left a flag set");
    chk_flag_sticky: assert property ( // RL5
        !vec_wr && flag_clr_i == 8'h00
        |=> (usb_status_flags_o & $past(usb_status_flags_o))
        == $past(usb_status_flags_o))
        else $error("flag fell without a clear");
    chk_bus_flag: assert property ( // RL5
        bus_reset_i |=> usb_status_flags_o[ufs_pkg::BIT_BUS_RESET])
        else $error("bus reset flag not set");
    chk_setup_set: assert property ( // RL5
        setup_det_i |=> usb_status_flags_o[ufs_pkg::BIT_SETUP])
        else $error("setup flag not set");

    // frame timer; a missed tick shows as an overrun gap
    chk_frame_period: assert property ( // RL9
        pseudo_sof_q |-> gap_q == GAP_FULL)
        else $error("pseudo sof period wrong");
    chk_gap_bound: assert property ( // RL9
        !pseudo_sof_q |-> gap_q < GAP_FULL)
        else $error("pseudo sof tick missed");

    cov_addr_set: cover property (fadr_wr ##1 fadr_q != 7'h00);
    cov_pseudo_frame_start_flag_tick: cover property (pseudo_sof_q);
    cov_vec_clr: cover property (
        vec_wr && usb_status_flags_o[ufs_pkg::BIT_SUSPEND]);
    cov_set_clr: cover property (suspend_det_i && vec_wr);
endmodule // ufs_regs

//--- test/ufs_usb_model.sv
// Purpose: usb side model raising detector pulses
// Assumes: go_i high for one cycle per event
// Notes: ev_o bits: bus rst, susp, resume, sof, setup, setup ow
module ufs_usb_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [2:0] ev_i,
    output logic [5:0] ev_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // pulses only, so a stuck level cannot mask a missed set
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 6; k++) begin
            ev_o[k] <= go_i && (ev_i == 3'(k));
        end
    end
endmodule // ufs_usb_model

//--- test/test_usb_function_address_status_regs.sv
// Purpose: self-checking bench for the address and status pair
// Assumes: frame count shortened to 16 cycles
// Notes: reads are queued and checked by a monitor
module test_usb_function_address_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, go = 1'b0, lock = 1'b1, rd_tk = 1'b0;
    logic [7:0] wd = 8'h00, clr = 8'h00, rdata, st, want, r;
    logic [6:0] dev_addr;
    logic ps;
    logic [7:0] ps_cnt = 8'h00;
    logic [5:0] ev;
    logic [2:0] evs = 3'h0;
    logic [7:0] q[$];
    logic [7:0] msk [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
    logic [31:0] seed = 32'h0000_0037;
    int error_cnt = 0, n_compared = 0;
    ufs_regs #(.FRAME_CYCLES(16)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .mem_addr_i(addr), .mem_wr_i(wr), .mem_rd_i(rd), .mem_wdata_i(wd),
        .mem_rdata_o(rdata), .bus_reset_i(ev[0]), .suspend_det_i(ev[1]),
        .resume_det_i(ev[2]), .sof_det_i(ev[3]), .setup_det_i(ev[4]),
        .setup_ow_det_i(ev[5]), .timer_locked_i(lock), .flag_clr_i(clr),
        .device_address_field_o(dev_addr), .usb_status_flags_o(st),
        .pseudo_sof_o(ps));
    ufs_usb_model i_usb (.clk_i(clk_i), .go_i(go), .ev_i(evs), .ev_o(ev));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // every field set each call, so no strobe is assigned twice per edge
    task automatic op(input logic w, input logic rr, input logic [15:0] a,
        input logic [7:0] d, input logic g, input logic [2:0] k,
        input logic [7:0] c);
        @(posedge clk_i);
        wr <= w;
        rd <= rr;
        addr <= a;
        wd <= d;
        go <= g;
        evs <= k;
        clr <= c;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        q.push_back(e);
        op(1'b0, 1'b1, a, 8'h00, 1'b0, 3'h0, 8'h00);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) rd_tk <= rd;
    // sampled away from the edge that launches the pulse
    always @(negedge clk_i) begin
        if (ps) begin
            ps_cnt <= ps_cnt + 8'h01;
        end
    end
    always @(negedge clk_i) begin
        if (rd_tk) begin
            want = q.pop_front();
            chk(rdata, want);
        end
    end
    initial begin
        repeat (1000) @(posedge clk_i);
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(16'hfffe, 8'h00);
        rdchk(16'hffff, 8'h00);
        rdchk(16'h1234, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = (i == 3) ? 8'hd5 : xs();
            op(1'b1, 1'b0, 16'hffff, r, 1'b0, 3'h0, 8'h00);
            op(1'b1, 1'b0, 16'hfffe, ~r, 1'b0, 3'h0, 8'h00);
            rdchk(16'hffff, {1'b0, r[6:0]});
            rdchk(16'hfffe, 8'h00);
            @(negedge clk_i);
            chk({1'b0, dev_addr}, {1'b0, r[6:0]});
        end
        $display("test address done");
        r = 8'h00;
        for (int k = 5; k >= 0; k--) begin
            op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b1, 3'(k), 8'h00);
            op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'h00);
            r = r | msk[k];
            rdchk(16'hfffe, r);
            @(negedge clk_i);
            chk(st, r);
        end
        chk({1'b0, dev_addr}, 8'h00);
        op(1'b1, 1'b0, 16'hffb2, xs(), 1'b0, 3'h0, 8'h00);
        rdchk(16'hfffe, r & 8'h87);
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'hff);
        rdchk(16'hfffe, 8'h00);
        $display("test flags done");
        // event and clear on one edge: the set must win
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b1, 3'h1, 8'h00);
        op(1'b1, 1'b0, 16'hffb2, 8'h00, 1'b0, 3'h0, 8'h00);
        rdchk(16'hfffe, 8'h40);
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b1, 3'h0, 8'h40);
        op(1'b1, 1'b0, 16'hffff, 8'h7f, 1'b0, 3'h0, 8'h00);
        rdchk(16'hffff, 8'h00);
        rdchk(16'hfffe, 8'h80);
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'h80);
        rdchk(16'hfffe, 8'h00);
        $display("test collide done");
        op(1'b1, 1'b0, 16'hffff, 8'h2a, 1'b1, 3'h1, 8'h00);
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'h00);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rdchk(16'hffff, 8'h00);
        rdchk(16'hfffe, 8'h00);
        $display("test reset again done");
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'h00);
        lock <= 1'b0;
        repeat (40) @(posedge clk_i);
        lock <= 1'b1;
        rdchk(16'hfffe, 8'h08);
        op(1'b1, 1'b0, 16'hffb2, 8'h00, 1'b0, 3'h0, 8'h00);
        rdchk(16'hfffe, 8'h00);
        op(1'b0, 1'b0, 16'h0000, 8'h00, 1'b0, 3'h0, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(ps_cnt, 8'h02);
        $display("test frame done");
        close_out();
    end
endmodule // test_usb_function_address_status_regs
